// ==== include/eps_pkg.sv ====
package eps_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int WAKE_PULSE_MS   = 50;
    localparam int WAKE_PULSE_CYC  = CLK_HZ / 1000 * WAKE_PULSE_MS;
    localparam int RESUME_MAX_MS   = 2;
    localparam int RESUME_MAX_CYC  = CLK_HZ / 1000 * RESUME_MAX_MS;
    localparam int ADDR_W          = 8;

    // Device register offsets
    localparam logic [7:0] OFS_PM_CTRL  = 8'h00;
    localparam logic [7:0] OFS_BYTE_TST = 8'h04;
    localparam logic [7:0] OFS_WAKE_IRQ = 8'h08;
    localparam logic [7:0] OFS_PHY_CTRL = 8'h0C;
    localparam logic [7:0] OFS_PHY_MODE = 8'h10;
    localparam logic [7:0] OFS_PHY_INT  = 8'h14;

    // power_mgmt_control fields
    localparam int PM_READY     = 0;
    localparam int PM_PIN_EN    = 1;
    localparam int PM_PULSE_SEL = 3;
    localparam int PM_WSRC_LO   = 4;
    localparam int PM_WFE       = 9;
    localparam int PM_PS_LO     = 12;
    localparam int PM_EWE       = 14;
    localparam logic [1:0] PS_D0    = 2'h0;
    localparam logic [1:0] PS_D1    = 2'h1;
    localparam logic [1:0] PS_D2    = 2'h2;
    localparam logic [1:0] WS_ENRG  = 2'h1;
    localparam logic [1:0] WS_FRAME = 2'h2;

    localparam int INT_WAKE     = 0;
    localparam int PHY_GPD      = 11;
    localparam int PHY_EDPD     = 13;
    localparam int PHY_INT_ENRG = 1;

    // Controller registers on AXI4-Lite
    localparam logic [7:0] CR_CMD    = 8'h00;
    localparam logic [7:0] CR_WDATA  = 8'h04;
    localparam logic [7:0] CR_STATUS = 8'h08;
    localparam logic [7:0] CR_RDATA  = 8'h0C;
    localparam int CMD_ADDR_LO = 8;
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_D2    = 2'h2;
    localparam logic [1:0] OP_WAKE  = 2'h3;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [3:0] {
        ST_D0     = 4'b0001,
        ST_D1     = 4'b0010,
        ST_D2     = 4'b0100,
        ST_RESUME = 4'b1000
    } eps_state_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_BUS  = 2'b10
    } eps_hstate_e;
endpackage

// ==== include/eps_if.sv ====
interface eps_if;
    import eps_pkg::*;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              ack;
    logic [31:0]       rdata;
    modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

// ==== logic/eps_device.sv ====
module eps_device
    import eps_pkg::*;
#(
    parameter int RESUME_CYC = RESUME_MAX_CYC,
    parameter int PULSE_CYC  = WAKE_PULSE_CYC
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    eps_if.dev        bus,
    input  wire logic wake_frame_seen,
    input  wire logic line_energy_present,
    output logic      ready,
    output logic      mac_clk_en,
    output logic      host_clk_en,
    output logic      phy_active,
    output logic      phy_reset,
    output logic      wake_pin,
    output logic      wake_irq
);
    if (RESUME_CYC < 1 || RESUME_CYC > RESUME_MAX_CYC || PULSE_CYC < 2)
    begin
        $error("eps_device: bad timing parameter");
    end

    localparam int RW = $clog2(RESUME_CYC + 1);
    localparam int PW = $clog2(PULSE_CYC + 1);

    eps_state_e    state;
    logic [RW-1:0] resume_cnt;
    logic [PW-1:0] pulse_cnt;
    logic [1:0]    wsrc;
    logic          armed;
    logic          pin_en;
    logic          pulse_sel;
    logic          wfe;
    logic          ewe;
    logic          wake_flag;
    logic          gpd;
    logic          edpd;
    logic          phy_int;
    logic          energy_s1;
    logic          energy;
    logic          energy_d;
    logic          evt_d;
    logic          take;
    logic          wr_ok;
    logic          wake_wr;
    logic          wake_evt;
    logic          evt_rise;
    logic [1:0]    ps_field;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign take     = bus.req && !bus.ack;
    assign ready    = state == ST_D0;
    assign wr_ok    = take && bus.wr && armed && ready;
    assign wake_wr  = take && bus.wr && hit(bus.addr, OFS_BYTE_TST)
                      && (state == ST_D1 || state == ST_D2);
    assign wake_evt = (wsrc[1] && wfe) || (wsrc[0] && ewe);
    assign evt_rise = wake_evt && !evt_d;
    assign ps_field = state == ST_D1 ? PS_D1 : (state == ST_D2 ? PS_D2 : PS_D0);

    // Bus logic stays clocked through resume so ready is never seen early
    assign mac_clk_en  = state != ST_D2;
    assign host_clk_en = state != ST_D2;
    // Receive path is dead until energy is seen, so leading packets can drop
    assign phy_active  = !gpd && (!edpd || energy);
    assign wake_irq    = wake_flag;

    always_ff @(posedge aclk)
    begin
        energy_s1 <= line_energy_present;
        energy    <= energy_s1;
        energy_d  <= energy;
        evt_d     <= wake_evt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= ST_D0;
        else
        begin
            case (state)
                ST_D0:
                begin
                    if (wr_ok && hit(bus.addr, OFS_PM_CTRL))
                    begin
                        if (bus.wdata[PM_PS_LO +: 2] == PS_D1)
                            state <= ST_D1;
                        else if (bus.wdata[PM_PS_LO +: 2] == PS_D2)
                            state <= ST_D2;
                    end
                end
                ST_D1, ST_D2:
                begin
                    if (wake_wr)
                        state <= ST_RESUME;
                end
                ST_RESUME:
                begin
                    if (resume_cnt == RW'(RESUME_CYC - 1))
                        state <= ST_D0;
                end
                default:
                    state <= ST_D0;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state != ST_RESUME)
            resume_cnt <= '0;
        else
            resume_cnt <= resume_cnt + RW'(1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            armed <= 1'b0;
        else if (take && !bus.wr)
            armed <= 1'b1;
        else if (wake_wr || state != ST_D0)
            armed <= 1'b0;
    end

    // Enables survive both sleeps untouched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_en    <= 1'b0;
            pulse_sel <= 1'b0;
            wfe       <= 1'b0;
            ewe       <= 1'b0;
        end
        else if (wr_ok && hit(bus.addr, OFS_PM_CTRL))
        begin
            pin_en    <= bus.wdata[PM_PIN_EN];
            pulse_sel <= bus.wdata[PM_PULSE_SEL];
            wfe       <= bus.wdata[PM_WFE];
            ewe       <= bus.wdata[PM_EWE];
        end
    end

    // Detection beats a same-cycle write-1 clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wsrc <= 2'h0;
        else if (state == ST_D1 && wake_frame_seen)
            wsrc <= WS_FRAME;
        else if (state == ST_D2 && energy)
            wsrc <= WS_ENRG;
        else if (wr_ok && hit(bus.addr, OFS_PM_CTRL))
            wsrc <= wsrc & ~bus.wdata[PM_WSRC_LO +: 2];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_flag <= 1'b0;
        else if (wake_evt)
            wake_flag <= 1'b1;
        else if (wr_ok && hit(bus.addr, OFS_WAKE_IRQ) && bus.wdata[INT_WAKE])
            wake_flag <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !wake_evt)
            pulse_cnt <= '0;
        else if (evt_rise)
            pulse_cnt <= PW'(PULSE_CYC);
        else if (pulse_cnt != '0)
            pulse_cnt <= pulse_cnt - PW'(1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_pin <= 1'b0;
        else
            wake_pin <= pin_en && wake_evt
                        && (!pulse_sel || evt_rise || pulse_cnt > PW'(1));
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpd       <= 1'b0;
            edpd      <= 1'b0;
            phy_reset <= 1'b0;
        end
        else
        begin
            phy_reset <= wr_ok && hit(bus.addr, OFS_PHY_CTRL)
                         && gpd && !bus.wdata[PHY_GPD];
            if (wr_ok && hit(bus.addr, OFS_PHY_CTRL))
                gpd <= bus.wdata[PHY_GPD];
            if (wr_ok && hit(bus.addr, OFS_PHY_MODE))
                edpd <= bus.wdata[PHY_EDPD];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phy_int <= 1'b0;
        else if (edpd && energy && !energy_d)
            phy_int <= 1'b1;
        else if (wr_ok && hit(bus.addr, OFS_PHY_INT) && bus.wdata[PHY_INT_ENRG])
            phy_int <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus.ack   <= 1'b0;
            bus.rdata <= 32'h0;
        end
        else
        begin
            bus.ack <= take;
            if (take && !bus.wr)
            begin
                bus.rdata <= 32'h0;
                if (hit(bus.addr, OFS_PM_CTRL))
                begin
                    bus.rdata[PM_READY]       <= ready;
                    bus.rdata[PM_PIN_EN]      <= pin_en;
                    bus.rdata[PM_PULSE_SEL]   <= pulse_sel;
                    bus.rdata[PM_WSRC_LO +: 2] <= wsrc;
                    bus.rdata[PM_WFE]         <= wfe;
                    bus.rdata[PM_PS_LO +: 2]  <= ps_field;
                    bus.rdata[PM_EWE]         <= ewe;
                end
                // Other registers hidden until ready
                else if (ready && hit(bus.addr, OFS_WAKE_IRQ))
                    bus.rdata[INT_WAKE] <= wake_flag;
                else if (ready && hit(bus.addr, OFS_PHY_CTRL))
                    bus.rdata[PHY_GPD] <= gpd;
                else if (ready && hit(bus.addr, OFS_PHY_MODE))
                    bus.rdata[PHY_EDPD] <= edpd;
                else if (ready && hit(bus.addr, OFS_PHY_INT))
                    bus.rdata[PHY_INT_ENRG] <= phy_int;
            end
        end
    end
endmodule

// ==== logic/eps_host.sv ====
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module eps_host
    import eps_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    eps_if.ctl               bus,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    eps_hstate_e hstate;
    logic [1:0]  op;
    logic [1:0]  step;
    logic [7:0]  tgt;
    logic [31:0] wval;
    logic [31:0] rval;
    logic        refused;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_wr;
    logic        start;
    logic        dev_ready;
    logic        next_go;
    logic [1:0]  next_step;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction

    assign s_awready = !aw_got && !s_bvalid;
    assign s_wready  = !w_got && !s_bvalid;
    assign s_arready = !s_rvalid;
    assign do_wr     = aw_got && w_got && !s_bvalid;
    assign start     = do_wr && aw_addr == CR_CMD && hstate == H_IDLE;
    assign dev_ready = bus.rdata[PM_READY];

    // Decide the sequence step that follows an acknowledged access
    always_comb
    begin
        next_go   = 1'b0;
        next_step = step;
        case (op)
            OP_WRITE:
            begin
                next_go   = step == 2'h0 && (dev_ready || tgt == OFS_BYTE_TST);
                next_step = 2'h1;
            end
            OP_D2:
            begin
                next_go   = step != 2'h2;
                next_step = step + 2'h1;
            end
            OP_WAKE:
            begin
                next_go   = step != 2'h2;
                next_step = step == 2'h1 && !dev_ready ? 2'h1 : step + 2'h1;
            end
            default:
            begin
                next_go   = 1'b0;
                next_step = step;
            end
        endcase
    end

    // Load bus command for a given step
    task automatic issue(input logic [1:0] o, input logic [1:0] s, input logic [31:0] sh);
        bus.req   <= 1'b1;
        bus.wr    <= 1'b0;
        bus.addr  <= OFS_PM_CTRL;
        bus.wdata <= 32'h0;
        case ({o, s})
            {OP_READ, 2'h0}: bus.addr <= tgt;
            {OP_WRITE, 2'h1}:
            begin
                bus.wr    <= 1'b1;
                bus.addr  <= tgt;
                bus.wdata <= wval;
            end
            {OP_D2, 2'h1}:
            begin
                bus.wr              <= 1'b1;
                bus.addr            <= OFS_PHY_MODE;
                bus.wdata[PHY_EDPD] <= 1'b1;
            end
            {OP_D2, 2'h2}:
            begin
                bus.wr    <= 1'b1;
                bus.wdata <= sh;
                bus.wdata[PM_WSRC_LO +: 2] <= 2'h0;
                bus.wdata[PM_PS_LO +: 2]   <= PS_D2;
            end
            {OP_WAKE, 2'h0}:
            begin
                bus.wr   <= 1'b1;
                bus.addr <= OFS_BYTE_TST;
            end
            {OP_WAKE, 2'h2}:
            begin
                bus.wr   <= 1'b1;
                bus.addr <= OFS_PHY_MODE;
            end
            default: bus.wr <= 1'b0;
        endcase
    endtask

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hstate    <= H_IDLE;
            op        <= OP_READ;
            step      <= 2'h0;
            tgt       <= 8'h00;
            refused   <= 1'b0;
            rval      <= 32'h0;
            bus.req   <= 1'b0;
            bus.wr    <= 1'b0;
            bus.addr  <= 8'h00;
            bus.wdata <= 32'h0;
        end
        else
        begin
            case (hstate)
                H_IDLE:
                begin
                    if (start)
                    begin
                        op      <= w_data[1:0];
                        tgt     <= w_data[CMD_ADDR_LO +: 8];
                        step    <= 2'h0;
                        refused <= 1'b0;
                        hstate  <= H_BUS;
                        // Each sequence except a wake opens with a read, which also arms writes; a wake opens with the OFS_BYTE_TST write
                        issue(w_data[1:0] == OP_WAKE ? OP_WAKE : OP_READ, 2'h0, 32'h0);
                        if (w_data[1:0] != OP_WAKE)
                            bus.addr <= w_data[1:0] == OP_READ
                                        ? w_data[CMD_ADDR_LO +: 8] : OFS_PM_CTRL;
                    end
                end
                H_BUS:
                begin
                    if (bus.ack)
                    begin
                        if (!bus.wr)
                            rval <= bus.rdata;
                        if (next_go)
                        begin
                            step <= next_step;
                            issue(op, next_step, bus.wr ? rval : bus.rdata);
                        end
                        else
                        begin
                            refused <= op == OP_WRITE && step == 2'h0;
                            bus.req <= 1'b0;
                            hstate  <= H_IDLE;
                        end
                    end
                end
                default: hstate <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0;
            w_strb   <= 4'h0;
            wval     <= 32'h0;
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OK;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_got  <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_got  <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_wr)
            begin
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= (aw_addr == CR_CMD || aw_addr == CR_WDATA) ? RESP_OK : RESP_ERR;
                if (aw_addr == CR_WDATA)
                    wval <= merge(wval, w_data, w_strb);
            end
            else if (s_bready)
                s_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= RESP_OK;
        end
        else if (s_arvalid && s_arready)
        begin
            s_rvalid <= 1'b1;
            s_rresp  <= RESP_OK;
            s_rdata  <= 32'h0;
            case (s_araddr)
                CR_CMD:    s_rdata <= {16'h0, tgt, 6'h0, op};
                CR_WDATA:  s_rdata <= wval;
                CR_STATUS: s_rdata <= {29'h0, rval[PM_READY], refused, hstate == H_BUS};
                CR_RDATA:  s_rdata <= rval;
                default:   s_rresp <= RESP_ERR;
            endcase
        end
        else if (s_rready)
            s_rvalid <= 1'b0;
    end
endmodule

// ==== sim/eps_sva.sv ====
module eps_sva
    import eps_pkg::*;
#(
    parameter int RESUME_CYC = 20
)
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              req,
    input wire logic              wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       rdata,
    input wire logic              ack,
    input wire logic              ready,
    input wire logic              mac_clk_en,
    input wire logic              host_clk_en,
    input wire logic              wake_pin,
    input wire logic              wake_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack for the resume counter and bus latency
    localparam int RSM_MAX = RESUME_CYC + 4;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence taken_s;
        req && !ack;
    endsequence
    sequence wake_wr_s;
        taken_s ##0 (wr && addr == OFS_BYTE_TST && !ready);
    endsequence
    ack_answer_a: assert property (taken_s |=> ack)
        else $error("ack missing after request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    rdata_hold_a: assert property (!(ack && !wr) |-> $stable(rdata))
        else $error("rdata changed outside a read");
    resume_ready_a: assert property (wake_wr_s |-> ##[1:RSM_MAX] ready)
        else $error("ready late after wake write");
    sleep_gate_a: assert property (!mac_clk_en |-> !ready)
        else $error("ready while clocks stopped");
    ready_clk_a: assert property (ready |-> mac_clk_en && host_clk_en)
        else $error("ready before clocks restored");
    gate_pair_a: assert property (mac_clk_en == host_clk_en)
        else $error("mac and host clock gates differ");
    pin_irq_a: assert property ($rose(wake_pin) |-> ##[0:2] wake_irq)
        else $error("wake pin without wake flag");
endmodule

// ==== sim/testbench.sv ====
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import eps_pkg::*;
    localparam int RSM = 20;
    localparam int PLS = 16;
    logic        aclk, aresetn, frame_seen, energy, ready, mac_clk_en, host_clk_en;
    logic        phy_active, phy_reset, wake_pin, wake_irq;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, st, rd;
    logic [1:0]  s_bresp, s_rresp, last_resp;
    int          n_errors = 0;
    int          checks_done = 0;
    int          n_rst = 0;
    eps_if bus_if ();
    eps_device #(.RESUME_CYC(RSM), .PULSE_CYC(PLS)) u_eps_device (.aclk(aclk),
        .aresetn(aresetn), .bus(bus_if), .wake_frame_seen(frame_seen),
        .line_energy_present(energy), .ready(ready), .mac_clk_en(mac_clk_en),
        .host_clk_en(host_clk_en), .phy_active(phy_active), .phy_reset(phy_reset),
        .wake_pin(wake_pin), .wake_irq(wake_irq));
    eps_host u_eps_host (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
    eps_sva #(.RESUME_CYC(RSM)) u_eps_sva (.aclk(aclk), .aresetn(aresetn),
        .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr), .rdata(bus_if.rdata),
        .ack(bus_if.ack), .ready(ready), .mac_clk_en(mac_clk_en),
        .host_clk_en(host_clk_en), .wake_pin(wake_pin), .wake_irq(wake_irq));
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) if (phy_reset === 1'b1) n_rst++;
    task results;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end
        while (s_bvalid !== 1'b1);
        last_resp = s_bresp;
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end
        while (s_rvalid !== 1'b1);
        d = s_rdata;
        last_resp = s_rresp;
    endtask
    // Issue one controller command and wait for it to finish
    task op(input logic [1:0] o, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        axi_wr(CR_WDATA, d);
        axi_wr(CR_CMD, {16'h0000, a, 6'h00, o});
        `CHK("cmd resp", RESP_OK, last_resp)
        do
        begin
            axi_rd(CR_STATUS, st);
            k++;
        end
        while (st[0] !== 1'b0 && k < 300);
        `CHK("op done", 1'b0, st[0])
        axi_rd(CR_RDATA, rd);
    endtask
    task t_reset;
        `CHK("ready", 1'b1, ready)
        axi_rd(8'h40, rd);
        `CHK("unmapped resp", RESP_ERR, last_resp)
        op(OP_READ, OFS_PM_CTRL, 32'h0);
        `CHK("ready bit", 1'b1, rd[PM_READY])
    endtask
    task t_d1;
        op(OP_WRITE, OFS_PM_CTRL, 32'h0000_1202);
        `CHK("d1 ready", 1'b0, ready)
        `CHK("d1 mac clk", 1'b1, mac_clk_en)
        frame_seen <= 1'b1;
        @(posedge aclk);
        frame_seen <= 1'b0;
        cyc(4);
        `CHK("d1 pin", 1'b1, wake_pin)
        `CHK("d1 irq", 1'b1, wake_irq)
        op(OP_WRITE, OFS_PHY_CTRL, 32'h0);
        `CHK("refused", 1'b1, st[1])
        op(OP_WAKE, 8'h00, 32'h0);
        `CHK("wake ready", 1'b1, ready)
        op(OP_READ, OFS_PM_CTRL, 32'h0);
        `CHK("state", PS_D0, rd[PM_PS_LO+:2])
        `CHK("source", WS_FRAME, rd[PM_WSRC_LO+:2])
        `CHK("pin enable kept", 1'b1, rd[PM_PIN_EN])
        op(OP_WRITE, OFS_PM_CTRL, 32'h0000_0222);
        cyc(3);
        `CHK("pin cleared", 1'b0, wake_pin)
        `CHK("flag held", 1'b1, wake_irq)
        op(OP_WRITE, OFS_WAKE_IRQ, 32'h1);
        `CHK("flag cleared", 1'b0, wake_irq)
    endtask
    task t_d2;
        int k;
        op(OP_WRITE, OFS_PM_CTRL, 32'h0000_400A);
        op(OP_D2, 8'h00, 32'h0);
        `CHK("d2 mac clk", 1'b0, mac_clk_en)
        `CHK("d2 host clk", 1'b0, host_clk_en)
        `CHK("d2 ready", 1'b0, ready)
        `CHK("phy down", 1'b0, phy_active)
        energy <= 1'b1;
        for (k = 0; k < 10 && wake_pin !== 1'b1; k++) @(posedge aclk);
        `CHK("d2 pin", 1'b1, wake_pin)
        `CHK("phy up", 1'b1, phy_active)
        cyc(PLS - 2);
        `CHK("pulse high", 1'b1, wake_pin)
        cyc(3);
        `CHK("pulse end", 1'b0, wake_pin)
        op(OP_WAKE, 8'h00, 32'h0);
        energy <= 1'b0;
        op(OP_READ, OFS_PM_CTRL, 32'h0);
        `CHK("source", WS_ENRG, rd[PM_WSRC_LO+:2])
        `CHK("energy enable kept", 1'b1, rd[PM_EWE])
        op(OP_WRITE, OFS_WAKE_IRQ, 32'h1);
        `CHK("flag kept", 1'b1, wake_irq)
        op(OP_READ, OFS_PHY_INT, 32'h0);
        `CHK("energy flag", 1'b1, rd[PHY_INT_ENRG])
    endtask
    task t_gpd;
        op(OP_WRITE, OFS_PHY_CTRL, 32'h0000_0800);
        `CHK("gpd down", 1'b0, phy_active)
        op(OP_WRITE, OFS_PHY_CTRL, 32'h0);
        `CHK("phy reset", 1, n_rst)
        `CHK("gpd up", 1'b1, phy_active)
    endtask
    initial
    begin
        {aresetn, frame_seen, energy, s_awvalid, s_wvalid, s_bready} = '0;
        {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_d1();
        t_d2();
        t_gpd();
        results();
    end
    // Whole run needs a few hundred cycles
    initial
    begin
        #400_000;
        n_errors++;
        results();
    end
endmodule
